// ---- src/sopma_pkg.sv ----
`default_nettype none

package sopma_pkg;

  localparam int unsigned NUM_IN = 12;
  localparam int unsigned NUM_MC = 10;
  localparam int unsigned NUM_SIG = NUM_IN + NUM_MC;
  localparam int unsigned NUM_COL = 2 * NUM_SIG;
  localparam int unsigned PT_MAX = 16;

  // Product terms per macrocell, and where each group starts in the array
  localparam int unsigned PT_CNT [NUM_MC] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
  localparam int unsigned PT_BASE [NUM_MC] = '{0, 8, 18, 30, 44, 60, 76, 90, 102, 112};

  // Row map of the AND array
  localparam int unsigned OE_ROW_BASE = 120;
  localparam int unsigned AR_ROW = 130;
  localparam int unsigned SP_ROW = 131;
  localparam int unsigned NUM_ROW = 132;
  localparam int unsigned ROW_W = 8;
  localparam logic [ROW_W-1:0] LAST_ROW = 8'h83;
  localparam logic [ROW_W-1:0] CFG_ROW = 8'h84;

  // A cell bit of 1 is an erased cell: array link intact, mux control high
  typedef logic [NUM_ROW-1:0][NUM_COL-1:0] sopma_fuse_map_t;
  localparam sopma_fuse_map_t FUSE_ERASED = '1;
  localparam logic [NUM_MC-1:0] CFG_ERASED = 10'h3FF;

  // Power-up clear, longest time rounded down to whole cycles
  localparam int unsigned POR_NS = 1000;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned POR_CNT_W = 7;
  localparam logic [POR_CNT_W-1:0] POR_CYC = POR_CNT_W'(POR_NS / CLK_NS);

  localparam logic SECURE_RST = 1'b0;
  localparam logic ERASED_RST = 1'b0;

  typedef struct packed {
    logic ar;
    logic sp;
    logic preload;
    logic por_clr;
  } sopma_ctl_t;

  typedef struct packed {
    logic o;
    logic oe;
  } sopma_drive_t;

endpackage

`default_nettype wire

// ---- src/sopma_macrocell.sv ----
`default_nettype none

module sopma_macrocell (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sum_i,
  input wire logic oe_term_i,
  input wire logic pin_i,
  input wire logic polarity_select_bit_i,
  input wire logic register_bypass_select_bit_i,
  input wire sopma_pkg::sopma_ctl_t ctl_i,
  output var sopma_pkg::sopma_drive_t drv_o,
  output logic fb_o
);

  logic q_r;
  logic q_nxt;
  logic q_eff;
  logic d_sel;

  // Clear term acts at once on what is seen, then the flop follows
  assign q_eff = ctl_i.ar ? 1'b0 : q_r;

  always_comb begin
    if (ctl_i.por_clr || ctl_i.ar) begin
      q_nxt = 1'b0;
    end else if (ctl_i.preload) begin
      q_nxt = pin_i;
    end else if (ctl_i.sp) begin
      q_nxt = 1'b1;
    end else begin
      q_nxt = sum_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign d_sel = register_bypass_select_bit_i ? sum_i : q_eff;
  // One driver for the whole struct; buffers stay off while a tester forces the pins
  assign drv_o = '{
    o: polarity_select_bit_i ? d_sel : ~d_sel,
    oe: oe_term_i & ~ctl_i.preload
  };
  assign fb_o = register_bypass_select_bit_i ? pin_i : ~q_eff;

  sequence s_preload_req;
    ctl_i.preload && !ctl_i.ar && !ctl_i.por_clr;
  endsequence

  sequence s_preset_req;
    ctl_i.sp && !ctl_i.ar && !ctl_i.preload && !ctl_i.por_clr;
  endsequence

  property p_capture;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !ctl_i.sp && !ctl_i.ar && !ctl_i.preload && !ctl_i.por_clr |=> q_r == $past(sum_i);
  endproperty
  a_capture: assert property (p_capture) else $error("flop missed sum");

  property p_reg_fb;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !register_bypass_select_bit_i |-> fb_o == ~q_eff;
  endproperty
  a_reg_fb: assert property (p_reg_fb) else $error("bad registered feedback");

  property p_comb_out;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      register_bypass_select_bit_i |-> fb_o == pin_i && drv_o.o == (sum_i ~^ polarity_select_bit_i);
  endproperty
  a_comb_out: assert property (p_comb_out) else $error("bad combinatorial path");

  property p_oe;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !oe_term_i |-> !drv_o.oe;
  endproperty
  a_oe: assert property (p_oe) else $error("buffer on without term");

  property p_preset;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_preset_req ##1 !ctl_i.ar |->
        q_r && (register_bypass_select_bit_i || drv_o.o == polarity_select_bit_i);
  endproperty
  a_preset: assert property (p_preset) else $error("preset missed");

  property p_clear;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ctl_i.ar |-> q_eff == 1'b0 ##1 q_r == 1'b0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear not at once");

  property p_preload;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_preload_req |=> q_r == $past(pin_i);
  endproperty
  a_preload: assert property (p_preload) else $error("preload lost");

endmodule // sopma_macrocell

`default_nettype wire

// ---- src/sopma_array.sv ----
`default_nettype none

module sopma_array #(
  parameter sopma_pkg::sopma_fuse_map_t FUSE_MAP = sopma_pkg::FUSE_ERASED,
  parameter logic [sopma_pkg::NUM_MC-1:0] POL_CFG = sopma_pkg::CFG_ERASED,
  parameter logic [sopma_pkg::NUM_MC-1:0] BYP_CFG = sopma_pkg::CFG_ERASED
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [sopma_pkg::NUM_IN-1:0] in_i,
  input wire logic [sopma_pkg::NUM_MC-1:0] io_i,
  output logic [sopma_pkg::NUM_MC-1:0] io_o,
  output logic [sopma_pkg::NUM_MC-1:0] io_oe_o,
  input wire logic preload_i,
  input wire logic erase_i,
  input wire logic program_i,
  input wire logic secure_i,
  input wire logic [sopma_pkg::ROW_W-1:0] rd_row_i,
  output logic [sopma_pkg::NUM_COL-1:0] rd_data_o,
  output logic secured_o,
  output logic erased_o,
  output logic por_busy_o
);

  logic rst_s1_r;
  logic rst_n_r;
  logic [sopma_pkg::NUM_IN-1:0] in_s1_r;
  logic [sopma_pkg::NUM_IN-1:0] in_s2_r;
  logic [sopma_pkg::NUM_MC-1:0] io_s1_r;
  logic [sopma_pkg::NUM_MC-1:0] io_s2_r;
  logic [sopma_pkg::POR_CNT_W-1:0] por_cnt_r;
  logic secure_r;
  logic secure_nxt;
  logic erased_r;
  logic erased_nxt;
  logic [sopma_pkg::NUM_COL-1:0] rd_data_r;
  logic [sopma_pkg::NUM_COL-1:0] rd_data_nxt;

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Pins are asynchronous to the clock, so every input and I/O pin is synchronised; the control inputs are not
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
      io_s1_r <= '0;
      io_s2_r <= '0;
    end else begin
      in_s1_r <= in_i;
      in_s2_r <= in_s1_r;
      io_s1_r <= io_i;
      io_s2_r <= io_s1_r;
    end
  end

  // Power-up clear window
  logic por_busy;
  assign por_busy = por_cnt_r != sopma_pkg::POR_CYC;

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      por_cnt_r <= '0;
    end else if (por_busy) begin
      por_cnt_r <= por_cnt_r + 1'b1;
    end
  end

  // Security set wins over a clear arriving in the same cycle
  assign secure_nxt = secure_i | (secure_r & ~erase_i);
  assign erased_nxt = erase_i | (erased_r & ~program_i);

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      secure_r <= sopma_pkg::SECURE_RST;
      erased_r <= sopma_pkg::ERASED_RST;
    end else begin
      secure_r <= secure_nxt;
      erased_r <= erased_nxt;
    end
  end

  // Erase overrides the pattern with all cells erased; program restores it
  sopma_pkg::sopma_fuse_map_t fuse_eff;
  logic [sopma_pkg::NUM_MC-1:0] pol_eff;
  logic [sopma_pkg::NUM_MC-1:0] byp_eff;
  assign fuse_eff = erased_r ? sopma_pkg::FUSE_ERASED : FUSE_MAP;
  assign pol_eff = erased_r ? sopma_pkg::CFG_ERASED : POL_CFG;
  assign byp_eff = erased_r ? sopma_pkg::CFG_ERASED : BYP_CFG;

  // Array columns: true and inverted copy of each input and feedback
  logic [sopma_pkg::NUM_MC-1:0] fb;
  logic [sopma_pkg::NUM_SIG-1:0] sig;
  logic [sopma_pkg::NUM_COL-1:0] col;
  assign sig = {fb, in_s2_r};

  genvar k;
  generate
    for (k = 0; k < sopma_pkg::NUM_SIG; k++) begin : g_col
      assign col[2*k] = sig[k];
      assign col[2*k+1] = ~sig[k];
    end
  endgenerate

  // Unlinked columns count as true, so an empty term is one and a term
  // holding both forms of a signal is zero without special casing
  logic [sopma_pkg::NUM_ROW-1:0] pt;
  logic [sopma_pkg::NUM_ROW-1:0] empty_row;
  logic [sopma_pkg::NUM_ROW-1:0] clash_row;

  genvar r;
  generate
    for (r = 0; r < sopma_pkg::NUM_ROW; r++) begin : g_pt
      logic [sopma_pkg::NUM_SIG-1:0] t_link;
      logic [sopma_pkg::NUM_SIG-1:0] c_link;
      assign pt[r] = &(col | ~fuse_eff[r]);
      assign empty_row[r] = ~|fuse_eff[r];
      for (k = 0; k < sopma_pkg::NUM_SIG; k++) begin : g_lk
        assign t_link[k] = fuse_eff[r][2*k];
        assign c_link[k] = fuse_eff[r][2*k+1];
      end
      assign clash_row[r] = |(t_link & c_link);
    end
  endgenerate

  // Shared terms reach every macrocell
  sopma_pkg::sopma_ctl_t ctl;
  assign ctl = '{
    ar: pt[sopma_pkg::AR_ROW],
    sp: pt[sopma_pkg::SP_ROW],
    preload: preload_i & ~secure_r,
    por_clr: por_busy
  };

  genvar i;
  generate
    for (i = 0; i < sopma_pkg::NUM_MC; i++) begin : g_mc
      localparam logic [sopma_pkg::PT_MAX-1:0] SUM_MASK =
        sopma_pkg::PT_MAX'((32'h1 << sopma_pkg::PT_CNT[i]) - 32'h1);
      logic sum;
      sopma_pkg::sopma_drive_t drv;
      assign sum = |(pt[sopma_pkg::PT_BASE[i] +: sopma_pkg::PT_MAX] & SUM_MASK);

      sopma_macrocell u_mc (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_r),
        .sum_i(sum),
        .oe_term_i(pt[sopma_pkg::OE_ROW_BASE + i]),
        .pin_i(io_s2_r[i]),
        .polarity_select_bit_i(pol_eff[i]),
        .register_bypass_select_bit_i(byp_eff[i]),
        .ctl_i(ctl),
        .drv_o(drv),
        .fb_o(fb[i])
      );

      assign io_o[i] = drv.o;
      assign io_oe_o[i] = drv.oe;
    end
  endgenerate

  // Pattern readback; a secured part shows every cell erased
  logic row_in_array;
  logic [sopma_pkg::NUM_COL-1:0] cfg_word;
  logic [sopma_pkg::NUM_COL-1:0] row_word;
  assign row_in_array = rd_row_i <= sopma_pkg::LAST_ROW;
  assign cfg_word = {{(sopma_pkg::NUM_COL - 2 * sopma_pkg::NUM_MC){1'b0}}, byp_eff, pol_eff};
  assign row_word = row_in_array ? fuse_eff[rd_row_i] :
                    (rd_row_i == sopma_pkg::CFG_ROW) ? cfg_word : '0;
  assign rd_data_nxt = secure_r ? sopma_pkg::FUSE_ERASED[0] : row_word;

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data_o = rd_data_r;
  assign secured_o = secure_r;
  assign erased_o = erased_r;
  assign por_busy_o = por_busy;

  sequence s_erase;
    erase_i && !secure_i;
  endsequence

  sequence s_secured_read;
    secure_r ##1 secure_r;
  endsequence

  property p_empty_term;
    @(posedge ref_clk_i) disable iff (!rst_n_r)
      (pt & empty_row) == empty_row;
  endproperty
  a_empty_term: assert property (p_empty_term) else $error("empty term not one");

  property p_clash_term;
    @(posedge ref_clk_i) disable iff (!rst_n_r)
      (pt & clash_row) == '0;
  endproperty
  a_clash_term: assert property (p_clash_term) else $error("clashing term not zero");

  property p_por;
    @(posedge ref_clk_i) disable iff (!rst_n_r)
      por_busy |-> por_cnt_r < sopma_pkg::POR_CYC ##1 por_cnt_r == $past(por_cnt_r) + 1'b1;
  endproperty
  a_por: assert property (p_por) else $error("power-up clear overran");

  property p_secure_read;
    @(posedge ref_clk_i) disable iff (!rst_n_r)
      s_secured_read |-> rd_data_o == sopma_pkg::FUSE_ERASED[0] && !ctl.preload;
  endproperty
  a_secure_read: assert property (p_secure_read) else $error("secured pattern leaked");

  property p_secure_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_r)
      secure_r && !erase_i |=> secure_r;
  endproperty
  a_secure_hold: assert property (p_secure_hold) else $error("security lost without erase");

  property p_erase;
    @(posedge ref_clk_i) disable iff (!rst_n_r)
      s_erase |=> erased_r && !secure_r && pol_eff == sopma_pkg::CFG_ERASED && pt == '0;
  endproperty
  a_erase: assert property (p_erase) else $error("erase incomplete");

  property p_shared_clear;
    @(posedge ref_clk_i) disable iff (!rst_n_r)
      ctl.ar && !por_busy |=> (~byp_eff & (fb ^ {sopma_pkg::NUM_MC{1'b1}})) == '0;
  endproperty
  a_shared_clear: assert property (p_shared_clear) else $error("not all flops cleared");

endmodule // sopma_array

`default_nettype wire

// ---- testbench/sopma_board_model.sv ----
`default_nettype none

module sopma_board_model (
  input wire logic ref_clk_i,
  input wire logic [sopma_pkg::NUM_MC-1:0] dev_o_i,
  input wire logic [sopma_pkg::NUM_MC-1:0] dev_oe_i,
  input wire logic drive_en_i,
  input wire logic [sopma_pkg::NUM_MC-1:0] drive_val_i,
  output logic [sopma_pkg::NUM_MC-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [sopma_pkg::NUM_MC-1:0] last_r;
  logic [sopma_pkg::NUM_MC-1:0] board_nxt;

  // No pull on these pins: a floating pin must not look like a held value
  always_ff @(posedge ref_clk_i) begin
    last_r <= pin_o;
  end
  assign board_nxt = drive_en_i ? drive_val_i : ~last_r;
  // Board drives wherever the device has let go of the pin
  assign pin_o = (dev_oe_i & dev_o_i) | (~dev_oe_i & board_nxt);
endmodule // sopma_board_model

`default_nettype wire

// ---- testbench/tb.sv ----
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  function automatic sopma_pkg::sopma_fuse_map_t mk_map();
    sopma_pkg::sopma_fuse_map_t m;
    for (int r = 0; r < sopma_pkg::NUM_ROW; r++) begin
      m[r] = 44'h3; // Both forms of one input
    end
    m[0] = 44'h1;
    m[8] = 44'h4;
    m[18] = 44'h10;
    m[30] = 44'h0; // No links left
    m[44] = 44'h100000000;
    m[60] = 44'h400000000;
    for (int r = 120; r < 124; r++) begin
      m[r] = 44'h0;
    end
    m[130] = 44'h100000;
    m[131] = 44'h400000;
    return m;
  endfunction

  localparam sopma_pkg::sopma_fuse_map_t MAP = mk_map();
  localparam logic [9:0] POL = 10'h3F9;
  localparam logic [9:0] BYP = 10'h01A;

  logic ref_clk_i;
  logic nrst_i;
  logic [11:0] in_i;
  logic [9:0] io_i;
  logic [9:0] io_o;
  logic [9:0] io_oe_o;
  logic preload_i;
  logic erase_i;
  logic program_i;
  logic secure_i;
  logic [7:0] rd_row_i;
  logic [43:0] rd_data_o;
  logic secured_o;
  logic erased_o;
  logic por_busy_o;
  logic drive_en;
  logic [9:0] drive_val;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'h0055A034;
  int n;
  logic t;
  logic [7:0] rows [5] = '{8'h00, 8'h3C, 8'h83, 8'h84, 8'h90};

  sopma_array #(.FUSE_MAP(MAP), .POL_CFG(POL), .BYP_CFG(BYP)) sopma_array_i (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .in_i(in_i), .io_i(io_i), .io_o(io_o),
    .io_oe_o(io_oe_o), .preload_i(preload_i), .erase_i(erase_i), .program_i(program_i),
    .secure_i(secure_i), .rd_row_i(rd_row_i), .rd_data_o(rd_data_o),
    .secured_o(secured_o), .erased_o(erased_o), .por_busy_o(por_busy_o));

  sopma_board_model sopma_board_model_i (.ref_clk_i(ref_clk_i), .dev_o_i(io_o),
    .dev_oe_i(io_oe_o), .drive_en_i(drive_en), .drive_val_i(drive_val), .pin_o(io_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Cells 0..4 as programmed above, with cell 4 fed back from its pin
  function automatic logic [4:0] exp_low(logic [11:0] in, logic [9:0] pin);
    return {pin[4], 1'b1, ~in[2], ~in[1], in[0]};
  endfunction

  function automatic logic [43:0] exp_rd(logic [7:0] row);
    if (row < 8'h84) return MAP[row];
    if (row == 8'h84) return {24'h0, BYP, POL};
    return 44'h0;
  endfunction

  task automatic chk_vec(string nm, logic [43:0] e, logic [43:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(string nm, logic e, logic g);
    chk_vec(nm, 44'(e), 44'(g));
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  task automatic pulse(logic [2:0] w);
    @(posedge ref_clk_i);
    {program_i, erase_i, secure_i} <= w;
    @(posedge ref_clk_i);
    {program_i, erase_i, secure_i} <= 3'h0;
    cyc(2);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk_i);
    bad_count++;
    report_and_stop();
  end

  initial begin
    nrst_i = 1'b0;
    in_i = 12'h0;
    preload_i = 1'b0;
    erase_i = 1'b0;
    program_i = 1'b0;
    secure_i = 1'b0;
    rd_row_i = 8'h0;
    drive_en = 1'b1;
    drive_val = 10'h0;
    cyc(16);
    chk_flag("por_busy", 1'b1, por_busy_o);
    chk_vec("rst_regs", 44'h4, 44'(io_o[2:0] & 3'h5));
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    n = 0;
    while (por_busy_o !== 1'b0 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk_flag("por_len", 1'b1, n >= 100 && n <= 104);
    $display("test power-up done");
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk_i);
      in_i <= 12'($random(seed)) & 12'h3FF;
      drive_val <= 10'($random(seed));
      cyc(4);
      chk_vec("pins", 44'(exp_low(in_i, drive_val)), 44'(io_o[4:0]));
      chk_vec("oe", 44'h00F, 44'(io_oe_o));
      t = io_o[5];
      cyc(1);
      chk_flag("fb_toggle", 1'b1, t ^ io_o[5]);
    end
    $display("test random pins done");
    @(posedge ref_clk_i);
    in_i <= 12'h800;
    cyc(4);
    chk_vec("preset", 44'h3C1, 44'(io_o & 10'h3C5));
    @(posedge ref_clk_i);
    in_i <= 12'hC00;
    cyc(2);
    chk_vec("clear", 44'h004, 44'(io_o & 10'h3C5));
    $display("test preset clear done");
    @(posedge ref_clk_i);
    in_i <= 12'h0;
    preload_i <= 1'b1;
    drive_val <= 10'h2C0;
    cyc(5);
    chk_vec("pl_oe", 44'h0, 44'(io_oe_o));
    chk_vec("pl_state", 44'hB, 44'(io_o[9:6]));
    @(posedge ref_clk_i);
    preload_i <= 1'b0;
    cyc(2);
    chk_vec("pl_exit", 44'h0, 44'(io_o[9:6]));
    $display("test preload done");
    foreach (rows[i]) begin
      @(posedge ref_clk_i);
      rd_row_i <= rows[i];
      cyc(2);
      chk_vec("readback", exp_rd(rows[i]), rd_data_o);
    end
    rd_row_i <= 8'h0;
    pulse(3'b001);
    chk_flag("secured", 1'b1, secured_o);
    chk_vec("rd_secure", {44{1'b1}}, rd_data_o);
    @(posedge ref_clk_i);
    preload_i <= 1'b1;
    cyc(5);
    chk_vec("pl_blocked", 44'h0, 44'(io_o[9:6]));
    @(posedge ref_clk_i);
    preload_i <= 1'b0;
    pulse(3'b010);
    chk_flag("sec_erase", 1'b0, secured_o);
    chk_flag("erased", 1'b1, erased_o);
    cyc(3);
    chk_vec("er_oe", 44'h0, 44'(io_oe_o));
    chk_vec("er_pins", 44'h0, 44'(io_o));
    chk_vec("er_rd", {44{1'b1}}, rd_data_o);
    pulse(3'b011);
    chk_flag("sec_both", 1'b1, secured_o);
    pulse(3'b010);
    pulse(3'b100);
    chk_flag("programmed", 1'b0, erased_o);
    cyc(3);
    chk_vec("prog_oe", 44'h00F, 44'(io_oe_o));
    $display("test security erase done");
    report_and_stop();
  end
endmodule // tb

`default_nettype wire
